// ===== axi_ddr_throughput_master.sv
`timescale 1ns/1ns
module axi_ddr_throughput_master
(
   input wire logic clock_in, // system clock
   input wire logic rst_in, // sync reset, high
   input wire logic wb_cyc_in, // wishbone cycle
   input wire logic wb_stb_in, // wishbone strobe
   input wire logic wb_we_in, // wishbone write
   input wire logic [7:0] wb_adr_in, // wishbone byte address
   input wire logic [3:0] wb_sel_in, // wishbone byte selects
   input wire logic [31:0] wb_dat_in, // wishbone write data
   output logic [31:0] wb_dat_out, // wishbone read data
   output logic wb_ack_out, // wishbone ack
   input wire logic cmd_valid_in, // serial command byte valid
   input wire logic [7:0] cmd_byte_in, // serial command byte
   output logic count_valid_out, // count ready for serial path
   output logic [31:0] count_out, // measured cycles
   output logic count_is_read_out, // count belongs to a read
   output logic apb_psel_out, // apb select
   output logic apb_penable_out, // apb enable
   output logic apb_pwrite_out, // apb write
   output logic [15:0] apb_paddr_out, // apb address
   output logic [31:0] apb_pwdata_out, // apb write data
   input wire logic apb_pready_in, // apb ready
   output logic axi_awvalid_out, // write address valid
   input wire logic axi_awready_in, // write address ready
   output logic [31:0] axi_awaddr_out, // write address
   output logic [7:0] axi_awlen_out, // write burst length
   output logic [2:0] axi_awsize_out, // write beat size
   output logic [1:0] axi_awburst_out, // write burst type
   output logic axi_wvalid_out, // write data valid
   input wire logic axi_wready_in, // write data ready
   output logic [63:0] axi_wdata_out, // write data
   output logic [7:0] axi_wstrb_out, // write strobes
   output logic axi_wlast_out, // last write beat
   output logic axi_bready_out, // write response ready
   output logic axi_arvalid_out, // read address valid
   input wire logic axi_arready_in, // read address ready
   output logic [31:0] axi_araddr_out, // read address
   output logic [7:0] axi_arlen_out, // read burst length
   output logic [2:0] axi_arsize_out, // read beat size
   output logic [1:0] axi_arburst_out, // read burst type
   input wire logic axi_rvalid_in, // read data valid
   input wire logic [63:0] axi_rdata_in, // read data
   input wire logic axi_rlast_in, // last read beat
   output logic axi_rready_out, // read data ready
   output logic error_led_n_out // mismatch indicator, low lit
);
   ddr_tp_pkg::state_t state_reg; // sequencer state
   ddr_tp_pkg::state_t state_next; // its next value
   logic [3:0] cfg_idx_reg; // config table entry
   logic [3:0] cfg_idx_next; // its next value
   logic [11:0] settle_reg; // settling counter
   logic [8:0] nburst_reg; // bursts in this operation
   logic [8:0] issue_reg; // addresses issued
   logic [8:0] done_reg; // bursts of data finished
   logic [3:0] beat_reg; // write beat in burst
   logic [63:0] pattern_reg; // write data and read expectation
   logic [31:0] addr_reg; // current burst address
   logic [31:0] cycles_reg; // cycle counter
   logic [31:0] wcount_reg; // last write count
   logic [31:0] rcount_reg; // last read count
   logic op_read_reg; // operation is a read

   // table of tuned controller settings, address then data
   function automatic logic [47:0] cfg_entry(input logic [3:0] idx);
      logic [31:0] mode;
      mode = 32'h0;
      mode[ddr_tp_pkg::MODE_DDR3_BIT] = 1'b1;
      mode[ddr_tp_pkg::MODE_ECC_BIT] = 1'b0; // no ecc
      mode[ddr_tp_pkg::MODE_AXI_BIT] = 1'b1; // fabric port is axi
      mode[ddr_tp_pkg::MODE_WIDTH_LSB +: 2] = ddr_tp_pkg::WIDTH32_CODE;
      unique case (idx)
         4'h0: cfg_entry = {12'h000, idx, mode};
         4'h1: cfg_entry = {12'h000, idx, ddr_tp_pkg::T_RAS_MIN};
         4'h2: cfg_entry = {12'h000, idx, ddr_tp_pkg::T_RAS_MAX};
         4'h3: cfg_entry = {12'h000, idx, ddr_tp_pkg::T_RCD};
         4'h4: cfg_entry = {12'h000, idx, ddr_tp_pkg::T_RP};
         4'h5: cfg_entry = {12'h000, idx, ddr_tp_pkg::T_REFI};
         4'h6: cfg_entry = {12'h000, idx, ddr_tp_pkg::T_RC};
         4'h7: cfg_entry = {12'h000, idx, ddr_tp_pkg::T_RFC};
         4'h8: cfg_entry = {12'h000, idx, ddr_tp_pkg::T_FAW};
         default: cfg_entry = {12'h000, idx, 32'(ddr_tp_pkg::SETTLE_US)};
      endcase
   endfunction : cfg_entry

   // decode of bus, commands and handshakes
   wire in_wr = (state_reg == ddr_tp_pkg::ST_WRITE); // write running
   wire in_rd = (state_reg == ddr_tp_pkg::ST_READ); // read running
   wire init_done = (state_reg >= ddr_tp_pkg::ST_IDLE); // controller usable
   wire wb_req = wb_cyc_in & wb_stb_in & ~wb_ack_out; // new bus request
   wire wb_ctrl_wr = wb_req & wb_we_in & (wb_adr_in == ddr_tp_pkg::CTRL_OFS) & wb_sel_in[0];
   wire sw_go = wb_ctrl_wr & (wb_dat_in[ddr_tp_pkg::CTRL_WR_BIT] | wb_dat_in[ddr_tp_pkg::CTRL_RD_BIT]);
   wire go = (state_reg == ddr_tp_pkg::ST_IDLE) & (cmd_valid_in | sw_go); // commands taken only in idle, others dropped
   wire go_read = cmd_valid_in ? cmd_byte_in[ddr_tp_pkg::CMD_READ_BIT]
                               : wb_dat_in[ddr_tp_pkg::CTRL_RD_BIT]; // read or write strobe
   wire [2:0] raw_code = cmd_valid_in ? cmd_byte_in[ddr_tp_pkg::CMD_SIZE_LSB +: 3]
                                      : wb_dat_in[ddr_tp_pkg::CTRL_SIZE_LSB +: 3]; // size field
   wire [2:0] size_code = (raw_code > ddr_tp_pkg::MAX_SIZE_CODE) ? ddr_tp_pkg::MAX_SIZE_CODE : raw_code;
   wire [8:0] nburst_m1 = nburst_reg - 9'h001; // index of final burst
   wire aw_hs = axi_awvalid_out & axi_awready_in; // write address taken
   wire ar_hs = axi_arvalid_out & axi_arready_in; // read address taken
   wire issue_last = (issue_reg == nburst_m1); // final address going out
   wire w_hs = axi_wvalid_out & axi_wready_in; // write beat taken
   wire wlast_hs = w_hs & axi_wlast_out; // write burst finished
   wire r_hs = in_rd & axi_rvalid_in & axi_rready_out; // read beat taken
   wire rlast_hs = r_hs & axi_rlast_in; // read burst finished
   wire w_final = wlast_hs & (done_reg == nburst_m1); // last wlast of operation
   wire r_final = rlast_hs & (done_reg == nburst_m1); // last rlast of operation
   wire mismatch = r_hs & (axi_rdata_in != pattern_reg); // compare against regenerated pattern
   wire apb_done = (state_reg == ddr_tp_pkg::ST_CFG_ACC) & apb_pready_in; // config write finished
   wire [47:0] cfg_now = cfg_entry(cfg_idx_next); // entry for next apb access
   assign cfg_idx_next = apb_done ? cfg_idx_reg + 4'h1 : cfg_idx_reg;
   assign axi_awaddr_out = addr_reg; // one burst address serves both channels
   assign axi_araddr_out = addr_reg;
   assign axi_wdata_out = pattern_reg; // incrementing pattern

   // wishbone read selection, unmapped reads give zero
   wire [31:0] status_word = {25'h0, state_reg, op_read_reg, ~error_led_n_out, ~init_done | in_wr | in_rd, init_done};
   wire [31:0] rd_mux = (wb_adr_in == ddr_tp_pkg::CTRL_OFS) ? {23'h0, nburst_reg} :
                        (wb_adr_in == ddr_tp_pkg::STATUS_OFS) ? status_word :
                        (wb_adr_in == ddr_tp_pkg::WCOUNT_OFS) ? wcount_reg :
                        (wb_adr_in == ddr_tp_pkg::RCOUNT_OFS) ? rcount_reg : 32'h0;

   // next state of the sequencer
   always_comb
   begin
      state_next = state_reg;
      unique case (state_reg)
         ddr_tp_pkg::ST_CFG: // apb setup phase, held until select is out
            state_next = apb_psel_out ? ddr_tp_pkg::ST_CFG_ACC : ddr_tp_pkg::ST_CFG;
         ddr_tp_pkg::ST_CFG_ACC: // apb access phase
            if (apb_done)
               state_next = (cfg_idx_reg == ddr_tp_pkg::CFG_LAST) ? ddr_tp_pkg::ST_SETTLE : ddr_tp_pkg::ST_CFG;
         ddr_tp_pkg::ST_SETTLE: // settling wait
            if (settle_reg == 12'(ddr_tp_pkg::SETTLE_CYCLES - 1))
               state_next = ddr_tp_pkg::ST_IDLE;
         ddr_tp_pkg::ST_IDLE: // wait for a command
            if (go)
               state_next = go_read ? ddr_tp_pkg::ST_READ : ddr_tp_pkg::ST_WRITE;
         ddr_tp_pkg::ST_WRITE: // write until final wlast
            if (w_final)
               state_next = ddr_tp_pkg::ST_REPORT;
         ddr_tp_pkg::ST_READ: // read until final rlast
            if (r_final)
               state_next = ddr_tp_pkg::ST_REPORT;
         ddr_tp_pkg::ST_REPORT: state_next = ddr_tp_pkg::ST_IDLE; // count handed out
         default: state_next = ddr_tp_pkg::ST_CFG; // unused code restarts init
      endcase
   end

   // sequencer, init index and settling counter
   always_ff @(posedge clock_in)
   begin
      state_reg <= rst_in ? ddr_tp_pkg::ST_CFG : state_next;
      cfg_idx_reg <= rst_in ? 4'h0 : cfg_idx_next;
      settle_reg <= (rst_in || state_reg != ddr_tp_pkg::ST_SETTLE) ? 12'h000 : settle_reg + 12'h001;
   end

   // apb master for controller initialisation
   always_ff @(posedge clock_in)
   begin
      apb_psel_out <= ~rst_in & (state_next == ddr_tp_pkg::ST_CFG || state_next == ddr_tp_pkg::ST_CFG_ACC);
      apb_penable_out <= ~rst_in & (state_next == ddr_tp_pkg::ST_CFG_ACC);
      apb_pwrite_out <= ~rst_in;
      apb_paddr_out <= rst_in ? 16'h0000 : cfg_now[47:32];
      apb_pwdata_out <= rst_in ? 32'h0000_0000 : cfg_now[31:0];
   end

   // fixed burst shape; response and read data always accepted
   always_ff @(posedge clock_in)
   begin
      axi_awlen_out <= rst_in ? 8'h00 : ddr_tp_pkg::AXI_LEN; // sixteen beats
      axi_arlen_out <= rst_in ? 8'h00 : ddr_tp_pkg::AXI_LEN;
      axi_awsize_out <= rst_in ? 3'h0 : ddr_tp_pkg::AXI_SIZE; // 64-bit beats
      axi_arsize_out <= rst_in ? 3'h0 : ddr_tp_pkg::AXI_SIZE;
      axi_awburst_out <= rst_in ? 2'h0 : ddr_tp_pkg::AXI_INCR;
      axi_arburst_out <= rst_in ? 2'h0 : ddr_tp_pkg::AXI_INCR;
      axi_wstrb_out <= rst_in ? 8'h00 : 8'hFF;
      axi_bready_out <= ~rst_in; // responses drained, never waited on
      axi_rready_out <= ~rst_in;
   end

   // address channels: issue while ready, no wait for responses
   always_ff @(posedge clock_in)
   begin
      if (rst_in || go)
         nburst_reg <= rst_in ? ddr_tp_pkg::BURSTS_MIN : ddr_tp_pkg::BURSTS_MIN << size_code; // size
      if (rst_in || go)
         issue_reg <= 9'h000;
      else if (aw_hs || ar_hs)
         issue_reg <= issue_reg + 9'h001;
      if (rst_in || go)
         addr_reg <= ddr_tp_pkg::START_ADDR; // start at zero
      else if (aw_hs || ar_hs)
         addr_reg <= addr_reg + ddr_tp_pkg::BURST_BYTES; // step 128 bytes
      if (rst_in || (aw_hs && issue_last))
         axi_awvalid_out <= 1'b0;
      else if (go && !go_read)
         axi_awvalid_out <= 1'b1; // next address without bresp
      if (rst_in || (ar_hs && issue_last))
         axi_arvalid_out <= 1'b0;
      else if (go && go_read)
         axi_arvalid_out <= 1'b1; // several reads outstanding
   end

   // write data channel and read checker share the pattern
   always_ff @(posedge clock_in)
   begin
      if (rst_in || go)
         pattern_reg <= 64'h0;
      else if (w_hs || r_hs)
         pattern_reg <= pattern_reg + 64'h1; // next expected or written value
      if (rst_in || go)
         beat_reg <= 4'h0;
      else if (w_hs)
         beat_reg <= beat_reg + 4'h1;
      if (rst_in || go)
         axi_wlast_out <= 1'b0;
      else if (w_hs)
         axi_wlast_out <= (beat_reg == ddr_tp_pkg::LAST_BEAT_M1); // sixteenth beat
      if (rst_in || w_final)
         axi_wvalid_out <= 1'b0;
      else if (go && !go_read)
         axi_wvalid_out <= 1'b1;
      if (rst_in || go)
         done_reg <= 9'h000;
      else if (wlast_hs || rlast_hs)
         done_reg <= done_reg + 9'h001;
      if (rst_in || go)
         error_led_n_out <= 1'b1; // held until next operation
      else if (mismatch)
         error_led_n_out <= 1'b0; // light indicator
   end

   // latency measurement and hand-off to the serial path
   always_ff @(posedge clock_in)
   begin
      if (rst_in || go)
         cycles_reg <= 32'h0; // in clock_in cycles of the system clock at CLOCK_KHZ
      else if (in_wr || in_rd)
         cycles_reg <= cycles_reg + 32'h1;
      if (rst_in || go)
         op_read_reg <= rst_in ? 1'b0 : go_read;
      count_valid_out <= ~rst_in & (state_reg == ddr_tp_pkg::ST_REPORT); // one pulse per operation
      if (rst_in || state_reg == ddr_tp_pkg::ST_REPORT)
         count_out <= rst_in ? 32'h0 : cycles_reg;
      if (rst_in || state_reg == ddr_tp_pkg::ST_REPORT)
         count_is_read_out <= rst_in ? 1'b0 : op_read_reg;
      if (rst_in || (state_reg == ddr_tp_pkg::ST_REPORT && !op_read_reg))
         wcount_reg <= rst_in ? 32'h0 : cycles_reg;
      if (rst_in || (state_reg == ddr_tp_pkg::ST_REPORT && op_read_reg))
         rcount_reg <= rst_in ? 32'h0 : cycles_reg;
   end

   // wishbone slave: ack one cycle after request, for one cycle
   always_ff @(posedge clock_in)
   begin
      wb_ack_out <= ~rst_in & wb_req;
      wb_dat_out <= rst_in ? 32'h0 : (wb_req ? rd_mux : wb_dat_out);
   end

   // checks
   default clocking cb @(posedge clock_in);
   endclocking
   default disable iff (rst_in);

   sequence wr_final_s;
      in_wr && w_final;
   endsequence
   sequence rd_final_s;
      in_rd && r_final;
   endsequence
   sequence report_s(logic rd);
      ##1 (state_reg == ddr_tp_pkg::ST_REPORT) ##1 (count_valid_out && count_is_read_out == rd);
   endsequence

   AST_NO_ACCESS_BEFORE_INIT: assert property (!init_done |-> !axi_awvalid_out && !axi_arvalid_out)
      else $error("memory access before init");
   AST_WR_COUNT_REPORT: assert property (wr_final_s |-> report_s(1'b0))
      else $error("write count not reported");
   AST_RD_COUNT_REPORT: assert property (rd_final_s |-> report_s(1'b1))
      else $error("read count not reported");
   AST_WR_COUNT_VALUE: assert property (wr_final_s |-> ##2 count_out == $past(cycles_reg, 2) + 32'h1)
      else $error("write count wrong");
   AST_RD_COUNT_VALUE: assert property (rd_final_s |-> ##2 count_out == $past(cycles_reg, 2) + 32'h1)
      else $error("read count wrong");
   AST_FIRST_ADDR_ZERO: assert property ($rose(axi_awvalid_out) || $rose(axi_arvalid_out) |-> addr_reg == 32'h0)
      else $error("first burst address not zero");
   AST_ADDR_STEP: assert property ((aw_hs || ar_hs) && !issue_last |=> addr_reg == $past(addr_reg) + 32'h80)
      else $error("burst address step wrong");
   AST_WLAST_SIXTEENTH: assert property (w_hs |-> axi_wlast_out == (beat_reg == 4'hF))
      else $error("wlast not on sixteenth beat");
   AST_WDATA_INCR: assert property (w_hs |=> axi_wdata_out == $past(axi_wdata_out) + 64'h1)
      else $error("write pattern not incrementing");
   AST_MISMATCH_LED: assert property (mismatch |=> !error_led_n_out)
      else $error("mismatch did not light indicator");
   AST_ERR_HOLD: assert property (!error_led_n_out && !go |=> !error_led_n_out)
      else $error("error status dropped early");
   AST_AW_NO_BRESP_WAIT: assert property (aw_hs && !issue_last |=> axi_awvalid_out)
      else $error("write address stalled");
   AST_AR_QUEUE: assert property (ar_hs && !issue_last |=> axi_arvalid_out)
      else $error("read address stalled");
endmodule : axi_ddr_throughput_master

// ===== ddr_slave_model.sv
`timescale 1ns/1ns
module ddr_slave_model
(
   input wire logic clock_in, // clock
   input wire logic rst_in, // sync reset
   input wire logic stall_in, // stall all channels
   input wire logic corrupt_in, // flip bit 0 of read data
   input wire logic arvalid_in, // read address valid
   input wire logic [31:0] araddr_in, // read address
   input wire logic rready_in, // read data ready
   output logic awready_out, // write address ready
   output logic wready_out, // write data ready
   output logic arready_out, // read address ready
   output logic pready_out, // config port ready
   output logic rvalid_out, // read data valid
   output logic [63:0] rdata_out, // read data
   output logic rlast_out // last read beat
);
   logic [2:0] pend_reg; // bursts still owed
   logic [63:0] beat_reg; // beat number within the run
   logic hold_reg; // rvalid stuck until taken
   wire ar_hs = arvalid_in && arready_out; // address taken
   wire r_hs = rvalid_out && rready_in; // beat taken
   // at most four reads outstanding, then address ready drops
   assign arready_out = !stall_in && pend_reg < 3'h4;
   assign awready_out = !stall_in;
   assign wready_out = !stall_in;
   assign pready_out = !stall_in;
   // once raised, valid stays until the beat is taken
   assign rvalid_out = pend_reg != 3'h0 && (!stall_in || hold_reg);
   // idle data is inverted so a stale value never passes
   assign rdata_out = rvalid_out ? beat_reg ^ {63'h0, corrupt_in} : ~beat_reg;
   assign rlast_out = beat_reg[3:0] == 4'hF;
   // burst bookkeeping; a read of address zero restarts the pattern
   always_ff @(posedge clock_in)
   begin
      hold_reg <= !rst_in && rvalid_out && !rready_in;
      pend_reg <= rst_in ? 3'h0 : pend_reg + {2'h0, ar_hs} - {2'h0, r_hs && rlast_out};
      if (ar_hs && araddr_in == 32'h0)
         beat_reg <= 64'h0;
      else if (r_hs)
         beat_reg <= beat_reg + 64'h1;
   end
endmodule : ddr_slave_model

// ===== ddr_tp_pkg.sv
// Operation
// - write count: first awvalid to final wlast
// - read count: first arvalid to final rlast
// - write addresses start zero, step 128 bytes
// - read addresses start zero, step 128 bytes
// - write an incrementing data pattern
// - read mismatch lights active-low error indicator
// - hand cycle count out after each operation
// - decode serial command into strobes and sizes
// - master takes command, lengths, address, data
// - initialise controller with tuned values over apb
// - timing in memory clocks: refresh, max active
// - controller fabric port set to axi
// - fabric logic runs from conditioned clock; here all logic runs from clock_in at CLOCK_KHZ
// - 32-bit memory data width, no ecc
// - apply 200 us memory settling time
// - sixteen-beat bursts on 64-bit data path
// - next write address without awaiting response
// - keep issuing read addresses while arready high
package ddr_tp_pkg;
   // wishbone register offsets (byte addresses)
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] STATUS_OFS = 8'h04;
   localparam logic [7:0] WCOUNT_OFS = 8'h08;
   localparam logic [7:0] RCOUNT_OFS = 8'h0C;
   // control register and command byte fields
   localparam int CTRL_WR_BIT = 0;
   localparam int CTRL_RD_BIT = 1;
   localparam int CTRL_SIZE_LSB = 4;
   localparam int CMD_READ_BIT = 7;
   localparam int CMD_SIZE_LSB = 0;
   localparam logic [2:0] MAX_SIZE_CODE = 3'h4;
   localparam logic [8:0] BURSTS_MIN = 9'h010;
   // axi burst shape
   localparam logic [7:0] AXI_LEN = 8'h0F;
   localparam logic [2:0] AXI_SIZE = 3'h3;
   localparam logic [1:0] AXI_INCR = 2'h1;
   localparam logic [3:0] LAST_BEAT_M1 = 4'hE;
   localparam logic [31:0] START_ADDR = 32'h0000_0000;
   localparam logic [31:0] BURST_BYTES = 32'h0000_0080;
   // clock rates
   localparam int CLOCK_KHZ = 20000;
   localparam int FABRIC_AXI_KHZ = 166600;
   // tuned memory timing, in memory clocks
   localparam logic [31:0] T_RAS_MIN = 32'd12;
   localparam logic [31:0] T_RAS_MAX = 32'd22528;
   localparam logic [31:0] T_RCD = 32'd5;
   localparam logic [31:0] T_RP = 32'd5;
   localparam logic [31:0] T_REFI = 32'd2592;
   localparam logic [31:0] T_RC = 32'd17;
   localparam logic [31:0] T_RFC = 32'd54;
   localparam logic [31:0] T_FAW = 32'd10;
   // settling time and its cycle count
   localparam int SETTLE_US = 200;
   localparam int SETTLE_CYCLES = (SETTLE_US * CLOCK_KHZ + 999) / 1000;
   // controller mode word fields
   localparam int MODE_DDR3_BIT = 0;
   localparam int MODE_ECC_BIT = 1;
   localparam int MODE_AXI_BIT = 2;
   localparam int MODE_WIDTH_LSB = 4;
   localparam logic [1:0] WIDTH32_CODE = 2'h2;
   localparam logic [3:0] CFG_LAST = 4'h9;
   // main sequencer states
   typedef enum logic [2:0]
   {
      ST_CFG = 3'h0,
      ST_CFG_ACC = 3'h1,
      ST_SETTLE = 3'h2,
      ST_IDLE = 3'h3,
      ST_WRITE = 3'h4,
      ST_READ = 3'h5,
      ST_REPORT = 3'h6
   } state_t;
endpackage : ddr_tp_pkg

// ===== test_axi_ddr_throughput_master.sv
`timescale 1ns/1ns
module test_axi_ddr_throughput_master;
   logic clock_in, rst_in, stall_in, corrupt_in, wb_cyc_in, wb_stb_in, wb_we_in, cmd_valid_in; // drives
   logic [7:0] wb_adr_in, cmd_byte_in, axi_awlen_out, axi_arlen_out, axi_wstrb_out; // bytes
   logic [3:0] wb_sel_in; // byte selects
   logic [31:0] wb_dat_in, wb_dat_out, count_out, rd_q, apb_pwdata_out, axi_awaddr_out, axi_araddr_out;
   logic wb_ack_out, count_valid_out, count_is_read_out, error_led_n_out, apb_psel_out; // status
   logic apb_penable_out, apb_pwrite_out, apb_pready_in, axi_awvalid_out, axi_awready_in; // strobes
   logic axi_wvalid_out, axi_wready_in, axi_wlast_out, axi_bready_out, axi_arvalid_out; // strobes
   logic axi_arready_in, axi_rvalid_in, axi_rlast_in, axi_rready_out, running = 1'b0, op_read, fin; // strobes
   logic [15:0] apb_paddr_out; // config address
   logic [2:0] axi_awsize_out, axi_arsize_out; // beat sizes
   logic [1:0] axi_awburst_out, axi_arburst_out; // burst types
   logic [63:0] axi_wdata_out, axi_rdata_in; // data paths
   int bad_count, checks_done, cfg_n, aw_n, w_n, ar_n, r_n, cyc_n, bursts; // bookkeeping
   int seed = 32'hF1F72B67; // fixed seed
   localparam logic [31:0] CFG_EXP [10] = '{32'h25, 32'hC, 32'h5800, 32'h5, 32'h5, 32'hA20, 32'h11, 32'h36,
      32'hA, 32'hC8}; // expected config words
   axi_ddr_throughput_master uut (.clock_in, .rst_in, .wb_cyc_in, .wb_stb_in, .wb_we_in, .wb_adr_in,
      .wb_sel_in, .wb_dat_in, .wb_dat_out, .wb_ack_out, .cmd_valid_in, .cmd_byte_in, .count_valid_out,
      .count_out, .count_is_read_out, .apb_psel_out, .apb_penable_out, .apb_pwrite_out, .apb_paddr_out,
      .apb_pwdata_out, .apb_pready_in, .axi_awvalid_out, .axi_awready_in, .axi_awaddr_out, .axi_awlen_out,
      .axi_awsize_out, .axi_awburst_out, .axi_wvalid_out, .axi_wready_in, .axi_wdata_out, .axi_wstrb_out,
      .axi_wlast_out, .axi_bready_out, .axi_arvalid_out, .axi_arready_in, .axi_araddr_out, .axi_arlen_out,
      .axi_arsize_out, .axi_arburst_out, .axi_rvalid_in, .axi_rdata_in, .axi_rlast_in, .axi_rready_out,
      .error_led_n_out);
   ddr_slave_model partner (.clock_in, .rst_in, .stall_in, .corrupt_in, .arvalid_in(axi_arvalid_out),
      .araddr_in(axi_araddr_out), .rready_in(axi_rready_out), .awready_out(axi_awready_in),
      .wready_out(axi_wready_in), .arready_out(axi_arready_in), .pready_out(apb_pready_in),
      .rvalid_out(axi_rvalid_in), .rdata_out(axi_rdata_in), .rlast_out(axi_rlast_in));
   // compare and count
   task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
      end
   endtask : check
   // verdict and end of run
   task automatic results();
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : results
   // one classic wishbone cycle, held until ack
   task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      wb_cyc_in <= 1'b1;
      wb_stb_in <= 1'b1;
      wb_we_in <= we;
      wb_adr_in <= adr;
      wb_dat_in <= d;
      do
      begin
         @(posedge clock_in);
         n++;
      end while (wb_ack_out !== 1'b1 && n < 50);
      q = wb_dat_out;
      if (n >= 50)
      begin
         bad_count++;
         results();
      end
      wb_cyc_in <= 1'b0;
      wb_stb_in <= 1'b0;
      @(posedge clock_in);
   endtask : wb_xfer
   // one command byte pulse
   task automatic send_cmd(input logic [7:0] b);
      cmd_byte_in <= b;
      cmd_valid_in <= 1'b1;
      @(posedge clock_in);
      cmd_valid_in <= 1'b0;
      @(posedge clock_in);
   endtask : send_cmd
   // one operation, a refused command while busy, then the report
   task automatic do_op(input logic rd, input logic [2:0] code, input logic use_wb, input logic bad);
      int n;
      n = 0;
      op_read = rd;
      corrupt_in <= bad;
      bursts = 16 << ((code > 4) ? 4 : code);
      if (use_wb)
         wb_xfer(1'b1, 8'h00, {25'h0, code, 2'h0, rd, !rd}, rd_q);
      else
         send_cmd({rd, 4'h0, code});
      send_cmd({!rd, 7'h01});
      while (count_valid_out !== 1'b1 && n < 20000)
      begin
         @(posedge clock_in);
         n++;
      end
      if (n >= 20000)
      begin
         bad_count++;
         results();
      end
      check("count", count_out, cyc_n);
      check("kind", count_is_read_out, rd);
      check("bursts", rd ? ar_n : aw_n, bursts);
      check("beats", rd ? r_n : w_n, bursts * 16);
      check("busy", rd ? aw_n : ar_n, 0);
      check("led", error_led_n_out, !bad);
      wb_xfer(1'b0, rd ? 8'h0C : 8'h08, 32'h0, rd_q);
      check("count reg", rd_q, cyc_n);
   endtask : do_op
   // clock
   initial
   begin
      clock_in = 1'b0;
      forever #25 clock_in = ~clock_in;
   end
   // random far-side stalls
   always @(posedge clock_in)
      stall_in <= ($random(seed) & 3) == 0;
   // watchdog
   initial
   begin
      #(80000 * 50);
      bad_count++;
      results();
   end
   // rebuild expected traffic and measure operation length
   always @(posedge clock_in)
   begin
      if (!running && (axi_awvalid_out || axi_arvalid_out))
         {aw_n, w_n, ar_n, r_n} = '0; // new operation starts its tallies
      if (!rst_in && apb_psel_out && apb_penable_out && apb_pready_in)
      begin
         check("cfg addr", apb_paddr_out, cfg_n);
         check("cfg write", apb_pwrite_out, 1'b1);
         check("cfg data", apb_pwdata_out, CFG_EXP[cfg_n]);
         cfg_n++;
      end
      if (axi_awvalid_out && axi_awready_in)
      begin
         check("awaddr", axi_awaddr_out, 128 * aw_n);
         check("awshape", {axi_awlen_out, axi_awsize_out, axi_awburst_out}, 13'h1ED);
         aw_n++;
      end
      if (axi_wvalid_out && axi_wready_in)
      begin
         check("wdata", axi_wdata_out, w_n);
         check("wlast", axi_wlast_out, w_n % 16 == 15);
         check("wstrb", {axi_wstrb_out, axi_bready_out, axi_rready_out}, 10'h3FF);
         w_n++;
      end
      if (axi_arvalid_out && axi_arready_in)
      begin
         check("araddr", axi_araddr_out, 128 * ar_n);
         check("arshape", {axi_arlen_out, axi_arsize_out, axi_arburst_out}, 13'h1ED);
         ar_n++;
      end
      r_n += axi_rvalid_in && axi_rready_out;
      fin = op_read ? axi_rvalid_in && axi_rready_out && axi_rlast_in && r_n == bursts * 16
         : axi_wvalid_out && axi_wready_in && axi_wlast_out && w_n == bursts * 16;
      if (running)
         cyc_n++;
      else if (axi_awvalid_out || axi_arvalid_out)
      begin
         running = 1'b1;
         cyc_n = 1;
         check("early", cfg_n, 10);
      end
      running = running && !fin;
   end
   // main sequence
   initial
   begin
      {rst_in, wb_cyc_in, wb_stb_in, wb_we_in, cmd_valid_in, corrupt_in} = 6'h20;
      {wb_adr_in, cmd_byte_in, wb_dat_in, rd_q, op_read, bursts} = '0;
      wb_sel_in = 4'hF;
      repeat (2) @(posedge clock_in);
      rst_in <= 1'b0;
      send_cmd(8'h00);
      for (int i = 0; i < 2000 && rd_q[0] !== 1'b1; i++)
         wb_xfer(1'b0, 8'h04, 32'h0, rd_q);
      check("init", cfg_n, 10);
      wb_xfer(1'b1, 8'h10, $random(seed), rd_q);
      wb_xfer(1'b0, 8'h10, 32'h0, rd_q);
      check("unmapped", rd_q, 0);
      for (int c = 0; c < 6; c++)
      begin
         do_op(1'b0, c[2:0], 1'b0, 1'b0);
         do_op(1'b1, c[2:0], 1'b0, 1'b0);
      end
      do_op(1'b1, 3'h1, 1'b0, 1'b1);
      do_op(1'b1, 3'h0, 1'b1, 1'b0);
      results();
   end
endmodule : test_axi_ddr_throughput_master
